// >>> include/dpr_pkg.sv
package dpr_pkg;

    // port pin, bus and timer widths
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int TOKEN_IDX_W = 3;
    localparam int TMR_W = 4;

    // clock and pin timing, in ns as specified
    localparam int CLK_NS = 10;
    localparam int WR_PULSE_NS = 12;
    localparam int RD_ACCESS_NS = 15;
    localparam int TOKEN_WR_RD_NS = 5;

    // least times rounded up to whole cycles
    localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int TOKEN_WR_RD_CYC = (TOKEN_WR_RD_NS + CLK_NS - 1) / CLK_NS;

    // timer reload values
    localparam logic [TMR_W-1:0] WR_LOAD = TMR_W'(WR_PULSE_CYC - 1);
    localparam logic [TMR_W-1:0] RD_LOAD = TMR_W'(RD_ACCESS_CYC - 1);
    localparam logic [TMR_W-1:0] GAP_LOAD = TMR_W'(TOKEN_WR_RD_CYC - 1);

    // data written to a token latch: bit 0 low requests, high releases
    localparam logic [DATA_W-1:0] TOKEN_TAKE_DATA = 8'hfe;
    localparam logic [DATA_W-1:0] TOKEN_GIVE_DATA = 8'hff;

    // pin levels after reset: all strobes inactive
    localparam logic [3:0] PINS_IDLE = 4'hf;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_TOKEN_TAKE = 3'h2,
        OP_TOKEN_GIVE = 3'h3,
        OP_TOKEN_PEEK = 3'h4
    } dpr_op_t;

    // gray codes along idle, setup, strobe, recover, gap
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_STROBE = 3'h3,
        ST_RECOVER = 3'h2,
        ST_GAP = 3'h6
    } dpr_state_t;

    typedef struct packed {
        dpr_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpr_req_t;

    typedef struct packed {
        logic ce_n;
        logic token_select_n;
        logic we_n;
        logic oe_n;
    } dpr_pins_t;

endpackage

// >>> rtl/dpr_timer.sv
`timescale 1ns/1ps
module dpr_timer (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // reload
    input wire logic load_i,
    input wire logic [dpr_pkg::TMR_W-1:0] load_val_i,
    // status
    output logic done_o
);

    logic [dpr_pkg::TMR_W-1:0] count;
    wire count_zero = (count == '0);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= load_val_i;
        end else if (!count_zero) begin
            count <= count - 1'b1;
        end
    end

    // no path from load back to done: the caller builds load from done
    assign done_o = count_zero;

endmodule

// >>> rtl/dpr_port_host.sv
`timescale 1ns/1ps
// Operation
// RULE1: the device writes only while a select and the write strobe are both low, ending when either rises.
// RULE2: write data must be stable around the rising edge that ends the write.
// RULE3: the write strobe stays high whenever the port address changes.
// RULE4: the device floats its data pins during a write even with output enable low.
// RULE5: array access uses chip select low with token select high, token access the reverse.
// RULE6: the write strobe stays high for the whole of a read.
// RULE7: a token request writes a low on the token bit line, with chip select high through write and readback.
// RULE8: when both ports race for one free token, exactly one port gets it.
// RULE9: when both ports hit one location too closely, exactly one port sees busy.
// RULE10: eight token latches exist, each owned by at most one port and freed on release.
module dpr_port_host (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // user command port
    input wire logic req_i,
    input dpr_pkg::dpr_req_t req_data_i,
    output logic ready_o,
    output logic done_o,
    output logic [dpr_pkg::DATA_W-1:0] rdata_o,
    output logic granted_o,
    // device port pins
    output dpr_pkg::dpr_pins_t pins_o,
    output logic [dpr_pkg::ADDR_W-1:0] addr_o,
    output logic [dpr_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [dpr_pkg::DATA_W-1:0] data_i,
    input wire logic busy_n_i
);

    dpr_pkg::dpr_state_t st;
    dpr_pkg::dpr_state_t next_st;
    dpr_pkg::dpr_op_t op;
    logic rb;
    logic tmr_done;

    // decode of the command being taken or held
    wire accept = (st == dpr_pkg::ST_IDLE) && req_i;
    wire dpr_pkg::dpr_op_t next_op = accept ? req_data_i.op : op;
    wire next_is_token = (next_op == dpr_pkg::OP_TOKEN_TAKE) ||
                         (next_op == dpr_pkg::OP_TOKEN_GIVE) ||
                         (next_op == dpr_pkg::OP_TOKEN_PEEK);
    wire accept_rd = (req_data_i.op == dpr_pkg::OP_READ) ||
                     (req_data_i.op == dpr_pkg::OP_TOKEN_PEEK);
    wire recover_to_gap = (op == dpr_pkg::OP_TOKEN_TAKE) && !rb;
    wire next_rb = accept ? accept_rd : (rb || (st == dpr_pkg::ST_GAP));
    wire is_token = (op == dpr_pkg::OP_TOKEN_TAKE) || (op == dpr_pkg::OP_TOKEN_GIVE) ||
                    (op == dpr_pkg::OP_TOKEN_PEEK);
    // busy arbitration only guards array cells, not token latches
    wire busy_ok = busy_n_i || is_token; // RULE9
    wire rd_capture = (st == dpr_pkg::ST_SETUP) && rb && tmr_done && busy_ok;

    always_comb begin
        next_st = st;
        case (st)
            dpr_pkg::ST_IDLE: begin
                if (req_i) begin
                    next_st = dpr_pkg::ST_SETUP;
                end
            end
            dpr_pkg::ST_SETUP: begin
                if (rd_capture) begin
                    next_st = dpr_pkg::ST_RECOVER;
                end else if (!rb && busy_ok) begin
                    next_st = dpr_pkg::ST_STROBE;
                end
            end
            dpr_pkg::ST_STROBE: begin
                if (tmr_done) begin
                    next_st = dpr_pkg::ST_RECOVER;
                end
            end
            dpr_pkg::ST_RECOVER: begin
                next_st = recover_to_gap ? dpr_pkg::ST_GAP : dpr_pkg::ST_IDLE;
            end
            dpr_pkg::ST_GAP: begin
                if (tmr_done) begin
                    next_st = dpr_pkg::ST_SETUP;
                end
            end
            default: begin
                next_st = dpr_pkg::ST_IDLE;
            end
        endcase
    end

    // pin levels for the coming cycle
    wire next_sel = (next_st == dpr_pkg::ST_SETUP) || (next_st == dpr_pkg::ST_STROBE) ||
                    (next_st == dpr_pkg::ST_RECOVER);
    wire next_ce_n = !(next_sel && !next_is_token); // RULE5 RULE7
    wire next_tok_n = !(next_sel && next_is_token); // RULE5
    wire next_we_n = (next_st != dpr_pkg::ST_STROBE); // RULE1 RULE6
    wire next_oe_n = !((next_st == dpr_pkg::ST_SETUP) && next_rb); // RULE4
    // data held through the recover cycle after the strobe rises
    wire next_data_oe = ((next_st == dpr_pkg::ST_STROBE) ||
                         (next_st == dpr_pkg::ST_RECOVER)) && !next_rb; // RULE2
    wire dpr_pkg::dpr_pins_t next_pins = '{ce_n: next_ce_n, token_select_n: next_tok_n,
                                           we_n: next_we_n, oe_n: next_oe_n};

    // token latches live at the low address bits only
    wire [dpr_pkg::ADDR_W-1:0] token_addr = {{(dpr_pkg::ADDR_W - dpr_pkg::TOKEN_IDX_W){1'b0}},
                                            req_data_i.addr[dpr_pkg::TOKEN_IDX_W-1:0]}; // RULE10
    wire accept_token = (req_data_i.op == dpr_pkg::OP_TOKEN_TAKE) ||
                        (req_data_i.op == dpr_pkg::OP_TOKEN_GIVE) ||
                        (req_data_i.op == dpr_pkg::OP_TOKEN_PEEK);
    wire [dpr_pkg::ADDR_W-1:0] next_addr = accept_token ? token_addr : req_data_i.addr;
    wire [dpr_pkg::DATA_W-1:0] next_data =
        (req_data_i.op == dpr_pkg::OP_TOKEN_TAKE) ? dpr_pkg::TOKEN_TAKE_DATA :
        (req_data_i.op == dpr_pkg::OP_TOKEN_GIVE) ? dpr_pkg::TOKEN_GIVE_DATA :
        req_data_i.wdata; // RULE7

    // timer reload on each timed state entry
    wire tmr_load = (next_st != st) && ((next_st == dpr_pkg::ST_SETUP) ||
                    (next_st == dpr_pkg::ST_STROBE) || (next_st == dpr_pkg::ST_GAP));
    wire [dpr_pkg::TMR_W-1:0] tmr_val =
        (next_st == dpr_pkg::ST_STROBE) ? dpr_pkg::WR_LOAD :
        (next_st == dpr_pkg::ST_GAP) ? dpr_pkg::GAP_LOAD : dpr_pkg::RD_LOAD;

    dpr_timer u_timer (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .done_o(tmr_done)
    );

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= dpr_pkg::ST_IDLE;
            op <= dpr_pkg::OP_READ;
            rb <= 1'b0;
        end else begin
            st <= next_st;
            op <= next_op;
            rb <= next_rb;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_o <= dpr_pkg::PINS_IDLE;
            data_oe_o <= 1'b0;
        end else begin
            pins_o <= next_pins;
            data_oe_o <= next_data_oe;
        end
    end

    // address and data only move while idle, strobe high
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_o <= '0;
            data_o <= '0;
        end else if (accept) begin
            addr_o <= next_addr; // RULE3
            data_o <= next_data; // RULE2
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
            granted_o <= 1'b0;
        end else if (rd_capture) begin
            rdata_o <= data_i;
            granted_o <= is_token && !data_i[0]; // RULE8
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_o <= 1'b1;
            done_o <= 1'b0;
        end else begin
            ready_o <= (next_st == dpr_pkg::ST_IDLE);
            done_o <= (st == dpr_pkg::ST_RECOVER) && !recover_to_gap;
        end
    end

    wire token_bit_line = data_o[0];

    a_write_needs_sel: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE1
        !pins_o.we_n |-> (!pins_o.ce_n || !pins_o.token_select_n))
        else $error("write strobe low with no select");

    a_write_pulse_len: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE1
        $fell(pins_o.we_n) |-> !pins_o.we_n [*2])
        else $error("write pulse shorter than two cycles");

    a_data_hold_end: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE2
        $rose(pins_o.we_n) |-> data_oe_o && $stable(data_o) && pins_o.oe_n)
        else $error("write data not held at write end");

    a_addr_we_high: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE3
        $changed(addr_o) |-> pins_o.we_n && $past(pins_o.we_n))
        else $error("address changed with write strobe low");

    a_no_drive_oe: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE4
        data_oe_o |-> pins_o.oe_n)
        else $error("host drives data while output enable low");

    a_select_excl: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE5
        !(pins_o.ce_n == 1'b0 && pins_o.token_select_n == 1'b0))
        else $error("chip select and token select both low");

    a_read_we_high: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE6
        !pins_o.oe_n |-> pins_o.we_n)
        else $error("write strobe low during read");

    a_token_take_bit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE7
        (!pins_o.we_n && op == dpr_pkg::OP_TOKEN_TAKE) |-> !token_bit_line && pins_o.ce_n)
        else $error("token request without low token bit");

    a_take_readback: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE7
        ($rose(pins_o.we_n) && op == dpr_pkg::OP_TOKEN_TAKE) |->
            ##[1:6] (!pins_o.oe_n && !pins_o.token_select_n && pins_o.ce_n))
        else $error("token readback missing after request");

    c_read_done: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        done_o && op == dpr_pkg::OP_READ);
    c_write_done: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        done_o && op == dpr_pkg::OP_WRITE);
    c_token_won: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        done_o && op == dpr_pkg::OP_TOKEN_TAKE && granted_o);
    c_token_lost: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        done_o && op == dpr_pkg::OP_TOKEN_TAKE && !granted_o);

endmodule

// >>> verif/dpr_dev_model.sv
`timescale 1ns/1ps
module dpr_dev_model (
    // port pins from host
    input wire logic [dpr_pkg::ADDR_W-1:0] addr_i,
    input dpr_pkg::dpr_pins_t pins_i,
    input wire logic [dpr_pkg::DATA_W-1:0] data_i,
    // latches held by the far port
    input wire logic [7:0] other_own_i,
    // device side of the data pins, latches held here and violation flag
    output logic [dpr_pkg::DATA_W-1:0] rd_o,
    output logic drv_o,
    output logic [7:0] own_o,
    output logic viol_o
);
    logic [dpr_pkg::DATA_W-1:0] mem [0:8191];
    logic [7:0] own = 8'h00;
    logic viol = 1'b0;
    logic tok_w;
    logic [dpr_pkg::ADDR_W-1:0] wa;
    logic [dpr_pkg::ADDR_W-1:0] seen_a;
    wire sel_arr = !pins_i.ce_n && pins_i.token_select_n;
    wire sel_tok = pins_i.ce_n && !pins_i.token_select_n;
    wire wr_act = !pins_i.we_n && (sel_arr || sel_tok);
    assign drv_o = pins_i.we_n && !pins_i.oe_n && (sel_arr || sel_tok);
    assign rd_o = sel_tok ? {8{~own[addr_i[2:0]]}} : mem[addr_i];
    assign own_o = own;
    assign viol_o = viol;
    always @(posedge wr_act) begin
        tok_w = sel_tok;
        wa = addr_i;
    end
    // data taken at the edge that ends the write
    always @(negedge wr_act) begin
        if (!tok_w) begin
            mem[wa] = data_i;
        end else if (data_i[0]) begin
            own[wa[2:0]] = 1'b0;
        end else if (!other_own_i[wa[2:0]]) begin
            own[wa[2:0]] = 1'b1;
        end
    end
    // checks wait until address and pins of one edge have all settled
    always @(addr_i or pins_i) begin
        #0;
        if (addr_i !== seen_a && pins_i.we_n === 1'b0) viol = 1'b1;
        if (!pins_i.ce_n && !pins_i.token_select_n) viol = 1'b1;
        if (!pins_i.we_n && !pins_i.oe_n) viol = 1'b1;
        seen_a = addr_i;
    end
endmodule

// >>> verif/dpr_port_host_tb.sv
`timescale 1ns/1ps
module dpr_port_host_tb;
    logic core_clk_i, rst_b_i, req, ready, done, granted, doe, busy_n, drv, viol;
    dpr_pkg::dpr_req_t req_data;
    dpr_pkg::dpr_pins_t pins;
    logic [12:0] addr;
    logic [7:0] rdata, dout, din, mrd, last_bus, other_own, own;
    logic [7:0] exp_mem [logic [12:0]];
    int failures, samples_checked;
    assign din = drv ? mrd : (doe ? dout : ~last_bus);
    always @(posedge core_clk_i) last_bus <= din;
    dpr_port_host uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_i(req),
        .req_data_i(req_data), .ready_o(ready), .done_o(done), .rdata_o(rdata),
        .granted_o(granted), .pins_o(pins), .addr_o(addr), .data_o(dout),
        .data_oe_o(doe), .data_i(din), .busy_n_i(busy_n));
    dpr_dev_model dev (.addr_i(addr), .pins_i(pins), .data_i(din), .other_own_i(other_own),
        .rd_o(mrd), .drv_o(drv), .own_o(own), .viol_o(viol));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic tally_and_finish();
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_tok(input logic [7:0] oth, input int i);
        return {8{oth[i]}};
    endfunction
    // called at a falling edge with ready high; returns at the first falling clock edge that sees done high
    task automatic cmd(input dpr_pkg::dpr_op_t op, input logic [12:0] a, input logic [7:0] d,
                       input int bc);
        int n;
        req_data.op = op;
        req_data.addr = a;
        req_data.wdata = d;
        req = 1'b1;
        busy_n = (bc == 0);
        @(negedge core_clk_i);
        req = 1'b0;
        repeat (bc) begin
            @(negedge core_clk_i);
            chk({7'h0, done}, 8'h00, "done during busy stall");
        end
        busy_n = 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n == 40) begin
            failures++;
            $display("[FAIL] %0t no done", $time);
            tally_and_finish();
        end
    endtask
    always @(negedge core_clk_i) begin
        if (rst_b_i && pins.we_n === 1'b0 && (pins.oe_n !== 1'b1 || doe !== 1'b1)) begin
            failures++;
            $display("[FAIL] %0t write strobe with output enable or bus released", $time);
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        failures++;
        $display("[FAIL] %0t run too long", $time);
        tally_and_finish();
    end
    initial begin
        logic [12:0] a;
        logic [7:0] d;
        void'($urandom(68));
        failures = 0;
        samples_checked = 0;
        rst_b_i = 1'b0;
        req = 1'b0;
        req_data = '0;
        busy_n = 1'b1;
        other_own = 8'h00;
        repeat (3) @(negedge core_clk_i);
        chk({4'h0, pins}, {4'h0, dpr_pkg::PINS_IDLE}, "pins after reset");
        rst_b_i = 1'b1;
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($urandom_range(0, 8191));
            d = 8'($urandom);
            cmd(dpr_pkg::OP_WRITE, a, d, (i % 4 == 3) ? int'($urandom_range(1, 6)) : 0);
            exp_mem[a] = d;
            cmd(dpr_pkg::OP_READ, a, 8'h00, (i % 5 == 4) ? int'($urandom_range(1, 6)) : 0);
            chk(rdata, exp_mem[a], "read after write");
            chk({7'h0, granted}, 8'h00, "grant after array read");
        end
        foreach (exp_mem[k]) begin
            cmd(dpr_pkg::OP_READ, k, 8'h00, 0);
            chk(rdata, exp_mem[k], "read back");
        end
        for (int r = 0; r < 3; r++) begin
            other_own = (r == 0) ? 8'h00 : (r == 1) ? 8'hff : 8'($urandom);
            for (int i = 0; i < 8; i++) begin
                cmd(dpr_pkg::OP_TOKEN_TAKE, 13'(i), 8'h00, 0);
                chk(rdata, exp_tok(other_own, i), "token readback");
                chk({7'h0, granted}, {7'h0, ~other_own[i]}, "token grant");
            end
            chk(own & other_own, 8'h00, "latch owned twice");
            for (int i = 0; i < 8; i++) begin
                cmd(dpr_pkg::OP_TOKEN_GIVE, 13'(i), 8'h00, 0);
                cmd(dpr_pkg::OP_TOKEN_PEEK, 13'(i), 8'h00, 0);
                chk({7'h0, granted}, 8'h00, "latch freed");
            end
        end
        a = 13'h0155;
        req_data.op = dpr_pkg::OP_WRITE;
        req_data.addr = a;
        req_data.wdata = 8'h3c;
        req = 1'b1;
        @(negedge core_clk_i);
        req = 1'b0;
        @(negedge core_clk_i);
        rst_b_i = 1'b0;
        exp_mem.delete(a);
        @(negedge core_clk_i);
        chk({4'h0, pins}, {4'h0, dpr_pkg::PINS_IDLE}, "pins in mid reset");
        chk({6'h0, doe, ready}, 8'h01, "bus and ready in mid reset");
        rst_b_i = 1'b1;
        d = 8'($urandom);
        cmd(dpr_pkg::OP_WRITE, 13'h0aaa, d, 0);
        cmd(dpr_pkg::OP_READ, 13'h0aaa, 8'h00, 2);
        chk(rdata, d, "read after second reset");
        chk({7'h0, viol}, 8'h00, "pin protocol");
        tally_and_finish();
    end
endmodule
